// [hdl/stp_consts.vh]
// constants for the stepper translator and pwm regulator
// assumes a 100 MHz core clock and a 32-bit axi4-lite register bus
`ifndef STP_CONSTS_VH
`define STP_CONSTS_VH

// clock rate and timing figures
`define STP_CLK_MHZ        100
`define STP_BLANK_NS       1000
`define STP_BLANK_CYC      ((`STP_BLANK_NS * `STP_CLK_MHZ) / 1000)
`define STP_OFF_US         30
`define STP_OFF_CYC        (`STP_OFF_US * `STP_CLK_MHZ)
`define STP_OHM_PER_US     825
// fast part of a mixed off period, 31.25 % = 5/16
`define STP_FAST_NUM       5
`define STP_FAST_SHIFT     4

// translator
`define STP_HOME_IDX       5'h04

// off-time strap modes
`define STP_STRAP_HIGH     2'h0
`define STP_STRAP_GROUND   2'h1
`define STP_STRAP_RES      2'h2

// pwm states
`define STP_PWM_ON         2'h0
`define STP_PWM_FAST       2'h1
`define STP_PWM_SLOW       2'h2

// register byte offsets
`define STP_REG_CFG        8'h00
`define STP_REG_STATUS     8'h04
`define STP_REG_LEVEL      8'h08

// cfg fields and reset values
`define STP_CFG_STRAP_LSB  0
`define STP_CFG_OFFUS_LSB  8
`define STP_CFG_STRAP_RST  2'h0
`define STP_CFG_OFFUS_RST  8'h1e

// status fields
`define STP_ST_IDX_LSB     0
`define STP_ST_POLA_BIT    8
`define STP_ST_POLB_BIT    9
`define STP_ST_MIXA_BIT    12
`define STP_ST_MIXB_BIT    13
`define STP_ST_HOLD_BIT    16
`define STP_ST_OFF_BIT     17

// level fields
`define STP_LV_A_LSB       0
`define STP_LV_B_LSB       8

// axi responses
`define STP_RESP_OKAY      2'h0
`define STP_RESP_SLVERR    2'h2

`endif

// [hdl/stp_translator_pwm.v]
// stepper translator with two fixed off-time pwm current regulators
// assumes step, direction and resolution pins from a motion controller,
// digital sense comparator results per winding and an axi4-lite master
//
// Overview of operation
// RULE_01: controller holds step high and low at least 1 us each.
// RULE_02: resolution pins decode to full, half, quarter, eighth step.
// RULE_03: reset or power-on loads home levels, polarities and mixed decay.
// RULE_04: each step rising edge advances one increment of set resolution.
// RULE_05: falling new level picks mixed decay, equal or higher picks slow.
// RULE_06: resolution changes apply only at the next step rising edge.
// RULE_07: direction changes apply only at the next step rising edge.
// RULE_08: controller changes resolution only at a shared position.
// RULE_09: overheat or overcurrent returns translator to home position.
// RULE_10: mixed off period is fast for 31.25 % then slow.
// RULE_11: reset holds home, turns all fets off, ignores step pulses.
// RULE_12: on phase drives diagonal pair; trip drops source or both.
// RULE_13: one-shot timer keeps fets off for fixed off-time.
// RULE_14: strap high gives 30 us and auto mixed, full step slow.
// RULE_15: strap grounded gives 30 us and mixed always.
// RULE_16: strap resistor gives ohms/825 us and auto mixed, full slow; code takes the off time in us from the cfg offUs field.
// RULE_17: comparators blanked about 1 us after every output switch; code does not reblank when a step flips polarity.
// RULE_18: trip level is per-step percentage of peak trip current.
// RULE_19: home is the 45 degree position, direction high as reference.
// RULE_20: enable high turns fets off while translator keeps running.
// RULE_21: controller waits 1 ms after sleep release before stepping.
// RULE_22: index moves 8, 4, 2 or 1 table entries per step.
// RULE_23: step, direction, resolution and reset pins are synchronised.
`timescale 1ns/1ps
`include "stp_consts.vh"

module stp_translator_pwm #(
   parameter BLANK_CYC = `STP_BLANK_CYC,
   parameter OFF_CYC   = `STP_OFF_CYC
) (
   input  wire        clk,
   input  wire        resetn,
   input  wire        ce,
   // controller pins
   input  wire        stepIn,
   input  wire        rotationWay,
   input  wire        resolutionSelectA,
   input  wire        resolutionSelectB,
   input  wire        resetPinN,
   input  wire        sleepN,
   input  wire        outputDisable,
   // protection and sense
   input  wire        overheatFault,
   input  wire        overcurrentFault,
   input  wire        windingACurrentInput,
   input  wire        windingBCurrentInput,
   // bridge gates {hiP, loP, hiN, loN}
   output reg  [3:0]  gateA,
   output reg  [3:0]  gateB,
   output reg  [7:0]  dacA,
   output reg  [7:0]  dacB,
   output wire        polA,
   output wire        polB,
   // axi4-lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   // eighth-step magnitude, 0..8 entries from full to zero current
   function [7:0] pctLevel;
      input [3:0] d;
      begin
         case (d)
            4'h0:    pctLevel = 8'hff; // 100.00 %
            4'h1:    pctLevel = 8'hfa; // 98.08 %
            4'h2:    pctLevel = 8'hec; // 92.39 %
            4'h3:    pctLevel = 8'hd4; // 83.15 %
            4'h4:    pctLevel = 8'hb4; // 70.71 %
            4'h5:    pctLevel = 8'h8e; // 55.56 %
            4'h6:    pctLevel = 8'h62; // 38.27 %
            4'h7:    pctLevel = 8'h32; // 19.51 %
            default: pctLevel = 8'h00;
         endcase
      end
   endfunction

   // winding a follows sine of the index angle
   function [7:0] sinMag;
      input [4:0] k;
      reg   [3:0] d;
      begin
         d = (k[3:0] >= 4'h8) ? (k[3:0] - 4'h8) : (4'h8 - k[3:0]);
         sinMag = pctLevel(d);
      end
   endfunction

   // winding b follows cosine of the index angle
   function [7:0] cosMag;
      input [4:0] k;
      reg   [4:0] d;
      begin
         d = (k[3:0] <= 4'h8) ? {1'b0, k[3:0]} : (5'h10 - {1'b0, k[3:0]});
         cosMag = pctLevel(d[3:0]);
      end
   endfunction

   // step size in table entries, {b, a} select
   function [4:0] stepInc;
      input [1:0] ms;
      begin
         case (ms)
            2'h0:    stepInc = 5'h08; // full [RULE_02] [RULE_22]
            2'h1:    stepInc = 5'h04; // half [RULE_02] [RULE_22]
            2'h2:    stepInc = 5'h02; // quarter [RULE_02] [RULE_22]
            default: stepInc = 5'h01; // eighth [RULE_02] [RULE_22]
         endcase
      end
   endfunction

   // bridge gates for one winding from polarity and pwm state
   function [3:0] bridgeGates;
      input       pol;
      input [1:0] st;
      begin
         case (st)
            `STP_PWM_ON:   bridgeGates = pol ? 4'h9 : 4'h6;
            `STP_PWM_FAST: bridgeGates = pol ? 4'h6 : 4'h9;
            `STP_PWM_SLOW: bridgeGates = pol ? 4'h1 : 4'h4;
            default:       bridgeGates = 4'h0;
         endcase
      end
   endfunction

   // counter-width copies so no assignment drops bits silently
   localparam [15:0] BLANK16  = BLANK_CYC;
   localparam [15:0] OFF16    = OFF_CYC;
   localparam [15:0] CLK_MHZ  = `STP_CLK_MHZ;
   localparam [19:0] FAST_NUM = `STP_FAST_NUM;

   reg  [5:0]  syncA;
   reg  [5:0]  syncB;
   reg         stepPrev;
   reg  [4:0]  idx;
   reg  [1:0]  mixDecay;
   reg  [1:0]  strapMode;
   reg  [7:0]  offUs;
   reg  [1:0]  pwmState [0:1];
   reg  [15:0] pwmCnt   [0:1];
   reg  [15:0] blankCnt [0:1];
   reg         awHeld;
   reg         wHeld;
   reg  [7:0]  awAddr;
   reg  [31:0] wData;
   reg  [3:0]  wStrb;
   integer     w;

   wire        stepS    = syncB[0];
   wire        dirS     = syncB[1];
   wire [1:0]  msS      = syncB[3:2];
   wire        rstPinS  = syncB[4];
   wire        sleepS   = syncB[5];
   wire        homeHold = !rstPinS | !sleepS | overheatFault
                          | overcurrentFault;
   wire        outputsOff = homeHold | outputDisable;
   wire        stepRise = stepS & !stepPrev;
   wire [4:0]  next_idx = dirS ? (idx + stepInc(msS))
                               : (idx - stepInc(msS));
   wire [7:0]  nextA    = sinMag(next_idx);
   wire [7:0]  nextB    = cosMag(next_idx);
   wire        fullStep = (msS == 2'h0);
   wire        alwaysMix = (strapMode == `STP_STRAP_GROUND);
   wire [15:0] offCycles;
   wire [19:0] fastProd = {4'h0, offCycles} * FAST_NUM;
   wire [15:0] fastCycles = fastProd[19:4];
   wire [15:0] slowCycles = offCycles - fastCycles;
   wire [1:0]  trip = {windingBCurrentInput, windingACurrentInput};
   wire [1:0]  pol;
   wire [15:0] resProd = {8'h00, offUs} * CLK_MHZ;

   assign polA = !idx[4];                                      // [RULE_19]
   assign polB = (idx[4] == idx[3]);                           // [RULE_19]
   assign pol  = {polB, polA};

   // grounded and high straps use the fixed time, resistor uses offUs
   assign offCycles = (strapMode == `STP_STRAP_RES) ? resProd
                                                   : OFF16;    // [RULE_16]

   // two-stage synchronisers; only stage b is looked at downstream
   always @(posedge clk) begin
      if (!resetn) begin
         syncA    <= 6'h00;
         syncB    <= 6'h00;
         stepPrev <= 1'b0;
      end else if (ce) begin
         syncA    <= {sleepN, resetPinN, resolutionSelectB,
                      resolutionSelectA, rotationWay, stepIn}; // [RULE_23]
         syncB    <= syncA;                                    // [RULE_23]
         stepPrev <= syncB[0];
      end
   end

   // translator: index, dac levels and per-winding decay choice
   always @(posedge clk) begin
      if (!resetn) begin
         idx      <= `STP_HOME_IDX;                            // [RULE_03]
         dacA     <= 8'hb4;                                    // [RULE_03]
         dacB     <= 8'hb4;
         mixDecay <= 2'h3;                                     // [RULE_03]
      end else if (ce) begin
         if (homeHold) begin
            // step pulses are dropped while held at home
            idx      <= `STP_HOME_IDX;                   // [RULE_09] [RULE_11]
            dacA     <= sinMag(`STP_HOME_IDX);
            dacB     <= cosMag(`STP_HOME_IDX);
            mixDecay <= 2'h3;
         end else if (stepRise) begin
            // resolution and direction are read only here
            idx  <= next_idx;               // [RULE_04] [RULE_06] [RULE_07]
            dacA <= nextA;                                     // [RULE_18]
            dacB <= nextB;                                     // [RULE_22]
            mixDecay[0] <= alwaysMix
                          | (!fullStep & (nextA < dacA));   // [RULE_05]
            mixDecay[1] <= alwaysMix
                          | (!fullStep & (nextB < dacB));   // [RULE_14]
         end
      end
   end

   // per-winding regulator: on, fast decay, slow decay
   always @(posedge clk) begin
      if (!resetn) begin
         for (w = 0; w < 2; w = w + 1) begin
            pwmState[w] <= `STP_PWM_ON;
            pwmCnt[w]   <= 16'h0000;
            blankCnt[w] <= BLANK16;
         end
      end else if (ce) begin
         for (w = 0; w < 2; w = w + 1) begin
            if (blankCnt[w] != 16'h0000)
               blankCnt[w] <= blankCnt[w] - 16'h0001;
            if (outputsOff) begin
               pwmState[w] <= `STP_PWM_ON;                  // [RULE_20]
               pwmCnt[w]   <= 16'h0000;
               blankCnt[w] <= BLANK16;
            end else begin
               case (pwmState[w])
                  `STP_PWM_ON: begin
                     // trips are ignored until blanking runs out
                     if (blankCnt[w] == 16'h0000 && trip[w]) begin
                        pwmState[w] <= mixDecay[w] ? `STP_PWM_FAST
                                                   : `STP_PWM_SLOW;
                        pwmCnt[w]   <= offCycles;           // [RULE_13]
                        blankCnt[w] <= BLANK16;             // [RULE_17]
                     end
                  end
                  `STP_PWM_FAST: begin
                     pwmCnt[w] <= pwmCnt[w] - 16'h0001;
                     if (pwmCnt[w] <= slowCycles) begin
                        pwmState[w] <= `STP_PWM_SLOW;       // [RULE_10]
                        blankCnt[w] <= BLANK16;             // [RULE_17]
                     end
                  end
                  `STP_PWM_SLOW: begin
                     if (pwmCnt[w] <= 16'h0001) begin
                        pwmState[w] <= `STP_PWM_ON;         // [RULE_13]
                        blankCnt[w] <= BLANK16;             // [RULE_17]
                     end else begin
                        pwmCnt[w] <= pwmCnt[w] - 16'h0001;
                     end
                  end
                  default: pwmState[w] <= `STP_PWM_ON;
               endcase
            end
         end
      end
   end

   // registered gate drive; all off while held or disabled
   always @(posedge clk) begin
      if (!resetn) begin
         gateA <= 4'h0;
         gateB <= 4'h0;
      end else if (ce) begin
         if (outputsOff) begin
            gateA <= 4'h0;                                  // [RULE_11]
            gateB <= 4'h0;                                  // [RULE_20]
         end else begin
            gateA <= bridgeGates(pol[0], pwmState[0]);      // [RULE_12]
            gateB <= bridgeGates(pol[1], pwmState[1]);      // [RULE_12]
         end
      end
   end

   // readies drop while frozen so nothing is taken without a clock enable
   assign s_axi_awready = ce & !awHeld & !s_axi_bvalid;
   assign s_axi_wready  = ce & !wHeld & !s_axi_bvalid;
   assign s_axi_arready = ce & !s_axi_rvalid;

   // write path: address and data taken in either order
   always @(posedge clk) begin
      if (!resetn) begin
         awHeld       <= 1'b0;
         wHeld        <= 1'b0;
         awAddr       <= 8'h00;
         wData        <= 32'h00000000;
         wStrb        <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `STP_RESP_OKAY;
         strapMode    <= `STP_CFG_STRAP_RST;
         offUs        <= `STP_CFG_OFFUS_RST;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (awHeld && wHeld && !s_axi_bvalid) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awAddr == `STP_REG_CFG) begin
               s_axi_bresp <= `STP_RESP_OKAY;
               if (wStrb[0])
                  strapMode <= wData[`STP_CFG_STRAP_LSB +: 2]; // [RULE_15]
               if (wStrb[1])
                  offUs <= wData[`STP_CFG_OFFUS_LSB +: 8];
            end else begin
               // read-only and unmapped words refuse the write
               s_axi_bresp <= `STP_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read path: one cycle from address to data
   always @(posedge clk) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `STP_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `STP_RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            case (s_axi_araddr)
               `STP_REG_CFG: begin
                  s_axi_rdata[`STP_CFG_STRAP_LSB +: 2] <= strapMode;
                  s_axi_rdata[`STP_CFG_OFFUS_LSB +: 8] <= offUs;
               end
               `STP_REG_STATUS: begin
                  s_axi_rdata[`STP_ST_IDX_LSB +: 5]  <= idx;
                  s_axi_rdata[`STP_ST_POLA_BIT]      <= polA;
                  s_axi_rdata[`STP_ST_POLB_BIT]      <= polB;
                  s_axi_rdata[`STP_ST_MIXA_BIT]      <= mixDecay[0];
                  s_axi_rdata[`STP_ST_MIXB_BIT]      <= mixDecay[1];
                  s_axi_rdata[`STP_ST_HOLD_BIT]      <= homeHold;
                  s_axi_rdata[`STP_ST_OFF_BIT]       <= outputsOff;
               end
               `STP_REG_LEVEL: begin
                  s_axi_rdata[`STP_LV_A_LSB +: 8] <= dacA;
                  s_axi_rdata[`STP_LV_B_LSB +: 8] <= dacB;
               end
               default: s_axi_rresp <= `STP_RESP_SLVERR; // unmapped
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // stp_translator_pwm

// [tb/stp_pwm_props.sv]
// checker for the stepper translator and pwm regulator ports
// assumes the reduced blank and off counts handed down by the bind
`timescale 1ns/1ps
module stp_pwm_props #(
   parameter BLANK_CYC = 4,
   parameter OFF_CYC   = 32
) (
   input wire       clk,
   input wire       resetn,
   input wire       stepIn,
   input wire       resetPinN,
   input wire       outputDisable,
   input wire       overheatFault,
   input wire       overcurrentFault,
   input wire [3:0] gateA,
   input wire [3:0] gateB,
   input wire [7:0] dacA,
   input wire [7:0] dacB,
   input wire       polA
);
   reg  [15:0] offCnt;
   reg  [15:0] fastCnt;
   wire [3:0]  onA = polA ? 4'h9 : 4'h6;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // run lengths of off and fast patterns; gates lag a polarity flip
   always @(posedge clk) begin
      if (!resetn || gateA == 4'h0 || (gateA == onA && $stable(polA)))
         offCnt <= 16'h0000;
      else
         offCnt <= offCnt + 16'h0001;
      if (!resetn || gateA != ~onA)
         fastCnt <= 16'h0000;
      else
         fastCnt <= fastCnt + 16'h0001;
   end

   AST_RESET_HOME: assert property (
      $rose(resetn) |-> dacA == 8'hb4 && dacB == 8'hb4 && polA)
      else $error("levels not at home after reset");
   AST_PIN_RESET_OFF: assert property (
      !resetPinN [*6] |-> gateA == 4'h0 && gateB == 4'h0 && dacA == 8'hb4)
      else $error("reset pin low but bridge driven");
   AST_FAULT_HOME: assert property (
      (overheatFault || overcurrentFault) [*3] |->
         dacA == 8'hb4 && dacB == 8'hb4 && gateA == 4'h0)
      else $error("fault did not return home");
   AST_DISABLE_OFF: assert property (
      outputDisable [*2] |-> gateA == 4'h0 && gateB == 4'h0)
      else $error("gates on while disabled");
   AST_NO_SHOOT: assert property (
      gateA[3:2] != 2'b11 && gateA[1:0] != 2'b11 &&
      gateB[3:2] != 2'b11 && gateB[1:0] != 2'b11)
      else $error("both fets of one leg on");
   AST_DAC_ON_STEP: assert property (
      $changed(dacA) && dacA != 8'hb4 |->
         $past(stepIn, 2) || $past(stepIn, 3) || $past(stepIn, 4))
      else $error("level moved without a step");
   AST_OFF_MAX: assert property (
      offCnt <= OFF_CYC + 2)
      else $error("off period too long");
   AST_OFF_MIN: assert property (
      gateA == onA && $stable(polA) && offCnt > 16'd2 |->
         offCnt >= OFF_CYC - 3)
      else $error("off period too short");
   AST_FAST_MAX: assert property (
      fastCnt <= OFF_CYC * 5 / 16 + 2)
      else $error("fast decay part too long");
   AST_BLANK: assert property (
      $changed(gateA) && gateA == onA && polA == $past(polA, 2) |=>
         (gateA == onA || gateA == 4'h0 || !$stable(polA)) [*2])
      else $error("on phase cut inside blanking");
endmodule // stp_pwm_props

bind stp_translator_pwm stp_pwm_props #(
   .BLANK_CYC(BLANK_CYC),
   .OFF_CYC  (OFF_CYC)
) i_props (.*);

// [tb/stp_ctrl_model.sv]
// motion controller model driving step, direction and resolution pins
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ps
module stp_ctrl_model #(
   parameter PULSE_CYC = 100
) (
   input  wire clk,
   output reg  stepIn,
   output reg  rotationWay,
   output reg  resolutionSelectA,
   output reg  resolutionSelectB
);
   // idle pins; full step is the pull-down default
   initial begin
      stepIn = 1'b0;
      rotationWay = 1'b1;
      {resolutionSelectB, resolutionSelectA} = 2'h0;
   end

   // pins move well before a step edge and stay through it
   task setPins(input logic dirIn, input logic [1:0] resIn);
      @(posedge clk);
      rotationWay <= dirIn;
      {resolutionSelectB, resolutionSelectA} <= resIn;
   endtask

   // one step of full width high and low
   task pulse;
      repeat (PULSE_CYC / 5) @(posedge clk);
      stepIn <= 1'b1;
      repeat (PULSE_CYC) @(posedge clk);
      stepIn <= 1'b0;
      repeat (PULSE_CYC) @(posedge clk);
   endtask
endmodule // stp_ctrl_model

// [tb/stepper_translator_pwm_ctrl_tb.sv]
// self-checking bench for the stepper translator and pwm regulator
// assumes the controller model and the bound checker beside the design
`timescale 1ns/1ps
module stepper_translator_pwm_ctrl_tb;
   logic        clk, resetn, ce, stepIn, rotationWay;
   logic        resolutionSelectA, resolutionSelectB, resetPinN, sleepN;
   logic        outputDisable, overheatFault, overcurrentFault;
   logic        windingACurrentInput, windingBCurrentInput, polA, polB;
   logic [3:0]  gateA, gateB, s_axi_wstrb;
   logic [7:0]  dacA, dacB, s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, gnd;
   logic [15:0] rnd;
   logic [4:0]  idx;
   int          error_cnt, num_checks;

   stp_translator_pwm #(.BLANK_CYC(4), .OFF_CYC(32)) i_dut (.*);
   stp_ctrl_model i_ctrl (.*);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic [15:0] lfsrNext(input [15:0] v);
      lfsrNext = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   // expected decay: grounded strap always mixed, full step slow
   function automatic logic expMix(input [1:0] res, input logic fall);
      expMix = gnd ? 1'b1 : (res == 2'h0 ? 1'b0 : fall);
   endfunction

   // expected level from the per-step percentage, 255 = 100 %
   function automatic logic [7:0] expLvl(input logic [4:0] k,
                                         input logic cosine);
      int p[9] = '{10000, 9808, 9239, 8315, 7071, 5556, 3827, 1951, 0};
      int dd;
      dd = cosine ? (k[3:0] <= 8 ? k[3:0] : 16 - k[3:0])
                  : (k[3:0] >= 8 ? k[3:0] - 8 : 8 - k[3:0]);
      expLvl = 8'((p[dd] * 255 + 5000) / 10000);
   endfunction

   // random comparator trips stand in for the sense resistors
   always @(posedge clk) begin
      rnd <= lfsrNext(rnd);
      windingACurrentInput <= rnd[0] & rnd[3];
      windingBCurrentInput <= rnd[1] & rnd[7];
   end

   task automatic check(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic axiRd(input logic [7:0] a, output logic [31:0] dd,
                        output logic [1:0] rr);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      dd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // address and data offered together, each dropped once taken
   task automatic axiWr(input logic [7:0] a, input logic [31:0] dd,
                        output logic [1:0] rr);
      logic aw, w;
      @(posedge clk);
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= dd;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (!aw && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge clk);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic chkHome;
      logic [31:0] st;
      logic [1:0]  rr;
      axiRd(8'h04, st, rr);
      check("homeIdx", 32'h4, 32'(st[4:0]));
      check("homeMix", 32'h3, 32'(st[13:12]));
      check("homeLvl", 32'hb4b4, 32'({dacB, dacA}));
      check("homePol", 32'h3, 32'({polB, polA}));
   endtask

   task automatic stepOnce(input logic dir, input logic [1:0] res);
      logic [4:0]  prv;
      logic [31:0] st;
      logic [1:0]  rr;
      prv = idx;
      i_ctrl.setPins(dir, res);
      axiRd(8'h04, st, rr);
      check("idxHeld", 32'(idx), 32'(st[4:0]));
      i_ctrl.pulse();
      idx = dir ? idx + (5'd8 >> res) : idx - (5'd8 >> res);
      axiRd(8'h04, st, rr);
      check("idx", 32'(idx), 32'(st[4:0]));
      check("lvlA", 32'(expLvl(idx, 1'b0)), 32'(dacA));
      check("lvlB", 32'(expLvl(idx, 1'b1)), 32'(dacB));
      check("mixA", 32'(expMix(res, expLvl(idx, 1'b0) < expLvl(prv, 1'b0))),
            32'(st[12]));
      check("mixB", 32'(expMix(res, expLvl(idx, 1'b1) < expLvl(prv, 1'b1))),
            32'(st[13]));
      if (res == 2'h0)
         check("fullLvl", 32'hb4, 32'(dacA));
   endtask

   task give_verdict;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // hang guard well beyond the expected run
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      give_verdict();
   end

   // main sequence
   initial begin
      {resetn, resetPinN, sleepN, outputDisable, overheatFault} = '0;
      overcurrentFault = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
      s_axi_rready = 1'b0;
      ce = 1'b1;
      gnd = 1'b0;
      rnd = 16'h000a;
      idx = 5'h04;
      error_cnt = 0;
      num_checks = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chkHome();
      check("gatesHeld", 32'h0, 32'({gateB, gateA}));
      resetPinN <= 1'b1;
      sleepN <= 1'b1;
      // settle after sleep release, scaled down like the blank and off counts
      repeat (4) @(posedge clk);
      axiRd(8'h00, d, r);
      check("cfgRst", 32'h00001e00, d);
      axiWr(8'h04, 32'h0, r);
      check("roResp", 32'h2, 32'(r));
      axiRd(8'h0c, d, r);
      check("unmapResp", 32'h2, 32'(r));
      check("unmapData", 32'h0, d);
      for (int i = 0; i < 24; i++)
         stepOnce(rnd[2], 2'(i / 6));
      gnd = 1'b1;
      axiWr(8'h00, 32'h00001e01, r);
      axiRd(8'h00, d, r);
      check("cfgGnd", 32'h00001e01, d);
      for (int i = 0; i < 4; i++)
         stepOnce(rnd[3], 2'(i));
      gnd = 1'b0;
      axiWr(8'h00, 32'h00001e00, r);
      outputDisable <= 1'b1;
      stepOnce(1'b1, 2'h1);
      check("gatesOff", 32'h0, 32'({gateB, gateA}));
      outputDisable <= 1'b0;
      // every hold source: steps lost, bridge off, back home
      for (int k = 0; k < 4; k++) begin
         stepOnce(1'b1, 2'h3);
         overheatFault <= (k == 0);
         overcurrentFault <= (k == 1);
         resetPinN <= (k != 2);
         sleepN <= (k != 3);
         repeat (6) @(posedge clk);
         i_ctrl.pulse();
         check("holdGates", 32'h0, 32'({gateB, gateA}));
         {overheatFault, overcurrentFault} <= 2'h0;
         {resetPinN, sleepN} <= 2'h3;
         repeat (4) @(posedge clk);
         idx = 5'h04;
         chkHome();
      end
      give_verdict();
   end
endmodule // stepper_translator_pwm_ctrl_tb
